// ### dvu_divide_unit.sv
// Operation
// RULE_01: unsigned word: low gets dividend, high cleared
// RULE_02: unsigned double: register pair loads high:low
// RULE_03: quotient in low, remainder in high
// RULE_04: sequencer issues eighteen executions, count seventeen
// RULE_05: fast core finishes in six executions
// RULE_06: unsigned divide always clears negative flag
// RULE_07: overflow flag when quotient does not fit
// RULE_08: zero flag when final remainder is zero
// RULE_09: carry holds algorithm state, value undefined
// RULE_10: unsigned overflow only in double form
// RULE_11: zero divisor raises trap on first execution
// RULE_12: interruptible each cycle, state kept for resume
// RULE_13: decode opcode fields high, low, size, divisor
// RULE_14: size bit selects 16 or 32 bit
// RULE_15: word form encodes high field as zero
// RULE_16: fraction: low cleared, dividend into high
// RULE_17: fraction remainder takes the dividend sign
// RULE_18: fraction negative flag follows remainder sign
// RULE_19: fraction needs dividend magnitude below divisor
// RULE_20: signed word: high filled with sign bit
// RULE_21: partial results live in work registers
`timescale 1ns/100ps
`default_nettype none
module dvu_divide_unit
    import dvu_pkg::*;
#(
    parameter bit FAST_CORE = 1'b0
) (
    input wire logic clk_i,
    input wire logic reset_i,
    dvu_if.dev lnk
);
    localparam int STEPS = FAST_CORE ? DVU_REP_FAST + 1 : DVU_REP_BASE + 1;
    localparam int ITERS = STEPS - 2;
    localparam int BPS = DVU_W / ITERS;
    localparam logic [4:0] ITERS_C = 5'(ITERS);

    typedef enum {DVU_IDLE, DVU_RUN} dvu_state_t;

    dvu_state_t state_ff;
    dvu_op_t op_ff;
    logic [4:0] iter_ff;
    logic [15:0] low_ff;
    logic [15:0] high_ff;
    logic [15:0] dmag_ff;
    logic dneg_ff;
    logic nneg_ff;
    logic pre_ov_ff;
    logic [3:0] flags_ff;
    logic carry_ff;
    logic trap_ff;
    logic done_ff;

    dvu_op_t dec_op;
    logic load_go;
    logic iter_go;
    logic fin_go;
    logic [31:0] raw;
    logic [31:0] absv;
    logic [32:0] it_res;
    logic [15:0] qv;
    logic [15:0] rv;
    logic [15:0] limit;
    logic ov_v;

    // one shift-subtract group; quotient bits shift in at the bottom of the low word
    function automatic logic [32:0] dvu_iter_f(input logic [15:0] rem_in,
                                               input logic [15:0] q_in,
                                               input logic [15:0] d);
        logic [15:0] rem;
        logic [15:0] q;
        logic [16:0] t;
        logic c;
        rem = rem_in;
        q = q_in;
        c = 1'b0;
        for (int k = 0; k < BPS; k++) begin
            t = {rem, q[15]};
            q = {q[14:0], 1'b0};
            c = (t >= {1'b0, d});
            if (c) begin
                t = t - {1'b0, d};
                q[0] = 1'b1;
            end
            rem = t[15:0];
        end
        return {c, rem, q};
    endfunction : dvu_iter_f

    assign dec_op = dvu_decode(lnk.instr); // [RULE_13]
    assign load_go = lnk.step && lnk.first && dec_op != DVU_OP_NONE;
    assign iter_go = lnk.step && !lnk.first && state_ff == DVU_RUN && iter_ff < ITERS_C;
    assign fin_go = lnk.step && !lnk.first && state_ff == DVU_RUN && iter_ff == ITERS_C;

    // the first iterating step also turns the documented raw load into magnitudes
    always_comb begin
        raw = {high_ff, low_ff};
        absv = raw;
        if (op_ff != DVU_OP_UNS && high_ff[15]) begin
            absv = 32'h0 - raw;
        end
        if (op_ff == DVU_OP_FRAC) begin
            absv = {1'b0, absv[31:1]}; // dividend sits as a q15 fraction
        end
    end

    always_comb begin
        if (iter_ff == 5'h0) begin
            it_res = dvu_iter_f(absv[31:16], absv[15:0], dmag_ff);
        end else begin
            it_res = dvu_iter_f(high_ff, low_ff, dmag_ff);
        end
    end

    always_comb begin
        qv = low_ff;
        rv = high_ff;
        limit = DVU_POS_LIMIT;
        if (op_ff != DVU_OP_UNS) begin
            if (nneg_ff ^ dneg_ff) begin
                qv = 16'h0 - low_ff;
            end
            if (nneg_ff) begin
                rv = 16'h0 - high_ff; // [RULE_17]
            end
            if (op_ff == DVU_OP_SGN && (nneg_ff ^ dneg_ff)) begin
                limit = DVU_NEG_LIMIT;
            end
        end
        ov_v = pre_ov_ff || (op_ff != DVU_OP_UNS && low_ff > limit); // [RULE_07] [RULE_19]
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_ff <= DVU_IDLE;
            op_ff <= DVU_OP_NONE;
            iter_ff <= 5'h0;
        end else if (load_go) begin
            op_ff <= dec_op;
            iter_ff <= 5'h0;
            // a zero divisor leaves the unit idle so later executions are ignored
            state_ff <= (lnk.divisor == 16'h0) ? DVU_IDLE : DVU_RUN;
        end else if (iter_go) begin
            iter_ff <= iter_ff + 5'h1; // [RULE_05]
        end else if (fin_go) begin
            state_ff <= DVU_IDLE;
        end
    end

    // work registers change only on a step, so a paused loop resumes intact
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            low_ff <= 16'h0;
            high_ff <= 16'h0;
        end else if (load_go) begin
            case (dec_op)
                DVU_OP_UNS: begin
                    low_ff <= lnk.dividend_lo; // [RULE_01]
                    high_ff <= lnk.instr[DVU_SIZE_BIT]
                               ? lnk.dividend_hi : 16'h0; // [RULE_02] [RULE_14]
                end
                DVU_OP_SGN: begin
                    low_ff <= lnk.dividend_lo;
                    if (lnk.instr[DVU_SIZE_BIT]) begin
                        high_ff <= lnk.dividend_hi; // [RULE_14]
                    end else begin
                        high_ff <= {DVU_W{lnk.dividend_lo[15]}}; // [RULE_20]
                    end
                end
                DVU_OP_FRAC: begin
                    low_ff <= 16'h0; // [RULE_16]
                    high_ff <= lnk.dividend_lo;
                end
                default: begin
                    low_ff <= low_ff;
                    high_ff <= high_ff;
                end
            endcase
        end else if (iter_go) begin
            high_ff <= it_res[31:16]; // [RULE_21] [RULE_12]
            low_ff <= it_res[15:0];
        end else if (fin_go) begin
            low_ff <= qv; // [RULE_03]
            high_ff <= rv;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            dmag_ff <= 16'h0;
            dneg_ff <= 1'b0;
        end else if (load_go) begin
            dneg_ff <= dec_op != DVU_OP_UNS && lnk.divisor[15];
            if (dec_op != DVU_OP_UNS && lnk.divisor[15]) begin
                dmag_ff <= 16'h0 - lnk.divisor;
            end else begin
                dmag_ff <= lnk.divisor;
            end
        end
    end

    // unsigned word form has a zero high word, so it can never trip this
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            nneg_ff <= 1'b0;
            pre_ov_ff <= 1'b0;
        end else if (load_go) begin
            pre_ov_ff <= 1'b0;
        end else if (iter_go && iter_ff == 5'h0) begin
            nneg_ff <= op_ff != DVU_OP_UNS && high_ff[15];
            pre_ov_ff <= absv[31:16] >= dmag_ff; // [RULE_10] [RULE_19]
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            carry_ff <= 1'b0;
        end else if (iter_go) begin
            carry_ff <= it_res[32]; // [RULE_09]
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            flags_ff <= 4'h0;
        end else if (fin_go) begin
            flags_ff[3] <= (op_ff == DVU_OP_UNS) ? 1'b0 : rv[15]; // [RULE_06] [RULE_18]
            flags_ff[2] <= ov_v; // [RULE_07]
            flags_ff[1] <= rv == 16'h0; // [RULE_08]
            flags_ff[0] <= carry_ff;
        end else begin
            flags_ff[0] <= carry_ff;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            trap_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            trap_ff <= load_go && lnk.divisor == 16'h0; // [RULE_11]
            done_ff <= fin_go;
        end
    end

    assign lnk.low_work = low_ff;
    assign lnk.high_work = high_ff;
    assign lnk.flags = flags_ff;
    assign lnk.trap = trap_ff;
    assign lnk.done = done_ff;
endmodule : dvu_divide_unit
`default_nettype wire

// ### dvu_pkg.sv
package dvu_pkg;
    localparam int DVU_W = 16;
    localparam logic [7:0] DVU_OPC_INT = 8'hd8;
    localparam logic [7:0] DVU_OPC_FRAC = 8'hd9;
    localparam int DVU_OPC_LSB = 16;
    localparam int DVU_SGN_BIT = 15;
    localparam int DVU_T_LSB = 11;
    localparam int DVU_V_LSB = 7;
    localparam int DVU_SIZE_BIT = 6;
    localparam int DVU_S_LSB = 0;
    localparam logic [1:0] DVU_INT_TAIL = 2'h0;
    localparam logic [7:0] DVU_FRAC_TAIL = 8'h00;
    localparam int DVU_REP_BASE = 17;
    localparam int DVU_REP_FAST = 5;
    localparam logic [3:0] DVU_LOW_IDX = 4'h0;
    localparam logic [3:0] DVU_HIGH_IDX = 4'h1;
    localparam logic [15:0] DVU_POS_LIMIT = 16'h7fff;
    localparam logic [15:0] DVU_NEG_LIMIT = 16'h8000;

    typedef enum {DVU_OP_NONE, DVU_OP_UNS, DVU_OP_SGN, DVU_OP_FRAC} dvu_op_t;

    function automatic dvu_op_t dvu_decode(input logic [23:0] ins);
        dvu_op_t op;
        op = DVU_OP_NONE;
        if (ins[23:DVU_OPC_LSB] == DVU_OPC_INT && ins[5:4] == DVU_INT_TAIL) begin
            op = ins[DVU_SGN_BIT] ? DVU_OP_UNS : DVU_OP_SGN;
        end else if (ins[23:DVU_OPC_LSB] == DVU_OPC_FRAC && !ins[DVU_SGN_BIT]
                     && ins[10:8] == 3'h0 && ins[7:4] == DVU_FRAC_TAIL[3:0]) begin
            op = DVU_OP_FRAC;
        end
        return op;
    endfunction : dvu_decode
endpackage : dvu_pkg

// ### dvu_if.sv
`timescale 1ns/100ps
`default_nettype none
interface dvu_if;
    logic step;
    logic first;
    logic [23:0] instr;
    logic [15:0] dividend_lo;
    logic [15:0] dividend_hi;
    logic [15:0] divisor;
    logic [15:0] low_work;
    logic [15:0] high_work;
    logic [3:0] flags;
    logic trap;
    logic done;
    modport dev(input step, first, instr, dividend_lo, dividend_hi, divisor,
                output low_work, high_work, flags, trap, done);
    modport host(output step, first, instr, dividend_lo, dividend_hi, divisor,
                 input low_work, high_work, flags, trap, done);
endinterface : dvu_if
`default_nettype wire

// ### dvu_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
module dvu_sequencer
    import dvu_pkg::*;
#(
    parameter bit FAST_CORE = 1'b0
) (
    input wire logic clk_i,
    input wire logic reset_i,
    dvu_if.host lnk,
    input wire logic start_i,
    input wire logic [23:0] instr_i,
    input wire logic irq_hold_i,
    input wire logic wr_en_i,
    input wire logic [3:0] wr_addr_i,
    input wire logic [15:0] wr_data_i,
    output logic busy_o,
    output logic done_o,
    output logic trap_o,
    output logic [15:0] quotient_o,
    output logic [15:0] remainder_o,
    output logic [3:0] flags_o
);
    localparam logic [4:0] REP_C = FAST_CORE ? 5'(DVU_REP_FAST) : 5'(DVU_REP_BASE);

    logic [15:0] rf_ff [16];
    logic busy_ff;
    logic [4:0] left_ff;
    logic first_ff;
    logic step_ff;
    logic [23:0] instr_ff;
    logic [15:0] lo_ff;
    logic [15:0] hi_ff;
    logic [15:0] div_ff;
    logic done_ff;
    logic trap_ff;
    logic [15:0] q_ff;
    logic [15:0] r_ff;
    logic [3:0] flags_ff;
    logic go;
    dvu_op_t op;

    assign op = dvu_decode(instr_i);
    assign go = start_i && !busy_ff && op != DVU_OP_NONE;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            for (int i = 0; i < 16; i++) begin
                rf_ff[i] <= 16'h0;
            end
        end else if (lnk.done) begin
            rf_ff[DVU_LOW_IDX] <= lnk.low_work;
            rf_ff[DVU_HIGH_IDX] <= lnk.high_work;
        end else if (wr_en_i) begin
            rf_ff[wr_addr_i] <= wr_data_i;
        end
    end

    // word form carries a zero high field, so the high operand read is harmless
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            instr_ff <= 24'h0;
            lo_ff <= 16'h0;
            hi_ff <= 16'h0;
            div_ff <= 16'h0;
        end else if (go) begin
            instr_ff <= instr_i; // [RULE_15]
            hi_ff <= rf_ff[instr_i[DVU_T_LSB +: 4]];
            div_ff <= rf_ff[instr_i[DVU_S_LSB +: 4]];
            if (op == DVU_OP_FRAC) begin
                lo_ff <= rf_ff[instr_i[DVU_T_LSB +: 4]];
            end else begin
                lo_ff <= rf_ff[instr_i[DVU_V_LSB +: 4]];
            end
        end
    end

    // a held interrupt simply withholds steps; the unit keeps its work registers
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            busy_ff <= 1'b0;
            left_ff <= 5'h0;
            first_ff <= 1'b0;
            step_ff <= 1'b0;
        end else if (go) begin
            busy_ff <= 1'b1;
            left_ff <= REP_C + 5'h1; // [RULE_04]
            first_ff <= 1'b1;
            step_ff <= 1'b0;
        end else if (lnk.trap || lnk.done) begin
            busy_ff <= 1'b0;
            left_ff <= 5'h0;
            step_ff <= 1'b0;
        end else if (busy_ff && left_ff != 5'h0 && !irq_hold_i) begin
            step_ff <= 1'b1; // [RULE_12]
            first_ff <= (left_ff == REP_C + 5'h1);
            left_ff <= left_ff - 5'h1;
        end else begin
            step_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            done_ff <= 1'b0;
            trap_ff <= 1'b0;
            q_ff <= 16'h0;
            r_ff <= 16'h0;
            flags_ff <= 4'h0;
        end else begin
            done_ff <= lnk.done;
            trap_ff <= lnk.trap;
            if (lnk.done) begin
                q_ff <= lnk.low_work;
                r_ff <= lnk.high_work;
                flags_ff <= lnk.flags;
            end
        end
    end

    assign lnk.step = step_ff;
    assign lnk.first = step_ff && first_ff;
    assign lnk.instr = instr_ff;
    assign lnk.dividend_lo = lo_ff;
    assign lnk.dividend_hi = hi_ff;
    assign lnk.divisor = div_ff;
    assign busy_o = busy_ff;
    assign done_o = done_ff;
    assign trap_o = trap_ff;
    assign quotient_o = q_ff;
    assign remainder_o = r_ff;
    assign flags_o = flags_ff;
endmodule : dvu_sequencer
`default_nettype wire

// ### dvu_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module dvu_monitor
    import dvu_pkg::*;
#(
    parameter bit FAST_CORE = 1'b0
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic step,
    input wire logic first,
    input wire logic [23:0] instr,
    input wire logic [15:0] dividend_lo,
    input wire logic [15:0] dividend_hi,
    input wire logic [15:0] divisor,
    input wire logic [15:0] low_work,
    input wire logic [15:0] high_work,
    input wire logic [3:0] flags,
    input wire logic trap,
    input wire logic done
);
    localparam int STEPS = FAST_CORE ? DVU_REP_FAST + 1 : DVU_REP_BASE + 1;
    logic ld, is_int, is_frac, uns_ff, frac_ff, sgn_ff;
    logic [4:0] cnt_ff;
    logic [15:0] dv_ff;
    logic [31:0] dd_ff;
    assign ld = step && first;
    assign is_int = instr[23:16] == DVU_OPC_INT && instr[5:4] == DVU_INT_TAIL;
    assign is_frac = instr[23:16] == DVU_OPC_FRAC && !instr[15] && instr[10:4] == 7'h00;
    // operands kept from the first step so the final flags can be judged
    always_ff @(posedge clk_i) begin
        if (ld) begin
            uns_ff <= is_int && instr[15];
            frac_ff <= is_frac;
            sgn_ff <= dividend_lo[15];
            dv_ff <= divisor;
            dd_ff <= instr[6] ? {dividend_hi, dividend_lo} : {16'h0000, dividend_lo};
        end
    end
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cnt_ff <= 5'h00;
        end else if (ld) begin
            cnt_ff <= 5'h01;
        end else if (step) begin
            cnt_ff <= cnt_ff + 5'h01;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    a_trap_zero_div: assert property (
        ld && (is_int || is_frac) && divisor == 16'h0000 |=> trap) else $error("no trap");
    a_trap_has_cause: assert property (
        trap |-> $past(ld) && $past(divisor) == 16'h0000) else $error("stray trap");
    a_done_step_count: assert property (
        done |-> cnt_ff == STEPS && $past(step)) else $error("wrong step count");
    a_done_one_cycle: assert property (
        done |=> !done) else $error("done too long");
    a_word_load: assert property (
        ld && is_int && instr[15] && !instr[6]
        |=> low_work == $past(dividend_lo) && high_work == 16'h0000) else $error("word load");
    a_pair_load: assert property (
        ld && is_int && instr[6] |=> {high_work, low_work} == {$past(dividend_hi),
        $past(dividend_lo)}) else $error("pair load");
    a_frac_load: assert property (
        ld && is_frac |=> low_work == 16'h0000 && high_work == $past(dividend_lo))
        else $error("fraction load");
    a_hold_between: assert property (
        !step |=> $stable(low_work) && $stable(high_work)) else $error("work regs moved");
    a_uns_result: assert property (
        done && uns_ff && !flags[2] |-> 32'(low_work) * 32'(dv_ff) + 32'(high_work) == dd_ff
        && high_work < dv_ff) else $error("bad quotient");
    a_uns_ovf_flag: assert property (
        done && uns_ff |-> flags[2] == (dd_ff[31:16] >= dv_ff)) else $error("overflow flag");
    a_uns_neg_clear: assert property (
        done && uns_ff |-> !flags[3]) else $error("negative flag set");
    a_zero_flag: assert property (
        done && !flags[2] |-> flags[1] == (high_work == 16'h0000)) else $error("zero flag");
    a_frac_sign: assert property (
        done && frac_ff && !flags[2] |-> flags[3] == high_work[15]
        && (high_work == 16'h0000 || high_work[15] == sgn_ff)) else $error("fraction sign");
endmodule : dvu_monitor
`default_nettype wire

// ### dvu_divide_unit_test.sv
`timescale 1ns/100ps
`default_nettype none
module dvu_divide_unit_test
    import dvu_pkg::*;
;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic start_i = 1'b0;
    logic irq_hold_i = 1'b0;
    logic wr_en_i = 1'b0;
    logic [23:0] instr_i = 24'h000000;
    logic [3:0] wr_addr_i = 4'h0;
    logic [15:0] wr_data_i = 16'h0000;
    logic busy_o, done_o, trap_o;
    logic [15:0] quotient_o, remainder_o;
    logic [3:0] flags_o;
    int fail_count = 0;
    int n_tests = 0;
    always #25 clk_i = ~clk_i;
    dvu_if lnk_if ();
    dvu_divide_unit dvu_divide_unit_inst (.clk_i(clk_i), .reset_i(reset_i), .lnk(lnk_if.dev));
    dvu_sequencer dvu_sequencer_inst (.clk_i(clk_i), .reset_i(reset_i), .lnk(lnk_if.host),
        .start_i(start_i), .instr_i(instr_i), .irq_hold_i(irq_hold_i), .wr_en_i(wr_en_i),
        .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i), .busy_o(busy_o), .done_o(done_o),
        .trap_o(trap_o), .quotient_o(quotient_o), .remainder_o(remainder_o),
        .flags_o(flags_o));
    dvu_monitor dvu_monitor_inst (.clk_i(clk_i), .reset_i(reset_i), .step(lnk_if.step),
        .first(lnk_if.first), .instr(lnk_if.instr), .dividend_lo(lnk_if.dividend_lo),
        .dividend_hi(lnk_if.dividend_hi), .divisor(lnk_if.divisor),
        .low_work(lnk_if.low_work), .high_work(lnk_if.high_work), .flags(lnk_if.flags),
        .trap(lnk_if.trap), .done(lnk_if.done));

    task automatic close_out();
        $display("comparisons=%0d mismatches=%0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    function automatic logic [23:0] ins_int(input logic u, input logic [3:0] t, v,
                                            input logic w, input logic [3:0] s);
        return {DVU_OPC_INT, u, t, v, w, 2'b00, s};
    endfunction : ins_int

    function automatic logic [23:0] ins_frac(input logic [3:0] t, s);
        return {DVU_OPC_FRAC, 1'b0, t, 7'h00, s};
    endfunction : ins_frac

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        wr_en_i <= 1'b1;
        wr_addr_i <= a;
        wr_data_i <= d;
        @(posedge clk_i);
        wr_en_i <= 1'b0;
    endtask : wr

    // hold > 0 pauses the steps for that many cycles and tries a second start meanwhile
    task automatic run(input logic [23:0] ins, input int hold, output int cyc);
        @(posedge clk_i);
        start_i <= 1'b1;
        instr_i <= ins;
        cyc = 0;
        do begin
            @(posedge clk_i);
            cyc++;
            start_i <= hold > 0 && cyc == 4;
            irq_hold_i <= hold > 0 && cyc >= 4 && cyc < 4 + hold;
            if (hold > 0 && cyc == 4) begin
                instr_i <= ins ^ 24'h00000f;
            end
            #1;
        end while (!done_o && !trap_o && cyc < 300);
    endtask : run

    task automatic divide(input logic [23:0] ins, input logic [15:0] hi, lo, dv,
                          input logic [31:0] res, input logic [3:0] fl, input int ecyc, hold);
        int cyc;
        wr(ins[10:7], lo);
        wr(ins[14:11], hi);
        wr(ins[3:0], dv);
        run(ins, hold, cyc);
        chk(done_o, 1'b1);
        if (fl[2]) begin
            chk(flags_o[2], 1'b1);
        end else begin
            chk(flags_o & 4'he, fl);
            chk({quotient_o, remainder_o}, res);
        end
        if (ecyc > 0) chk(cyc, ecyc);
    endtask : divide

    task automatic t_unsigned();
        divide(ins_int(1, 0, 2, 0, 4), 16'h1234, 16'h8000, 16'h0200,
               32'h00400000, 4'h2, 21, 0);
        divide(ins_int(1, 0, 3, 0, 4), 16'hffff, 16'h3000, 16'h0027,
               32'h013b0003, 4'h0, 21, 0);
        divide(ins_int(1, 11, 10, 1, 12), 16'h0042, 16'h2500, 16'h2200,
               32'h01f20100, 4'h0, 0, 0);
        divide(ins_int(1, 11, 10, 1, 12), 16'h21ff, 16'hffff, 16'h2200,
               32'hffff21ff, 4'h0, 0, 0);
        divide(ins_int(1, 11, 10, 1, 12), 16'h2200, 16'h0000, 16'h2200,
               32'h0, 4'h4, 0, 0);
    endtask : t_unsigned

    task automatic t_signed();
        divide(ins_int(0, 0, 3, 0, 4), 16'h0000, 16'hd000, 16'h0027,
               32'hfec5fffd, 4'h8, 0, 0);
        divide(ins_int(0, 13, 12, 1, 5), 16'hff42, 16'h2500, 16'h2200,
               32'hfa6bef00, 4'h8, 0, 0);
        // most negative word over minus one has no positive quotient
        divide(ins_int(0, 0, 3, 0, 4), 16'h0000, 16'h8000, 16'hffff,
               32'h0, 4'h4, 0, 0);
    endtask : t_signed

    task automatic t_fraction();
        divide(ins_frac(8, 9), 16'h1000, 16'h5555, 16'h4000,
               32'h20000000, 4'h2, 0, 0);
        divide(ins_frac(8, 9), 16'h1000, 16'h5555, 16'h8000,
               32'hf0000000, 4'h2, 0, 0);
        divide(ins_frac(8, 9), 16'h8002, 16'h0000, 16'h8001,
               32'h7ffe8002, 4'h8, 0, 0);
        divide(ins_frac(8, 9), 16'h4000, 16'h0000, 16'h4000, 32'h0, 4'h4, 0, 0);
    endtask : t_fraction

    task automatic t_zero_div();
        int cyc;
        wr(4'h2, 16'h7777);
        wr(4'h4, 16'h0000);
        run(ins_int(1, 0, 2, 0, 4), 0, cyc);
        chk(trap_o, 1'b1);
        chk(cyc < 6, 1'b1);
        repeat (24) @(posedge clk_i);
        #1;
        chk({busy_o, done_o}, 2'b00);
    endtask : t_zero_div

    task automatic t_pause();
        // ten withheld steps stretch the run from 21 to 31 cycles
        divide(ins_int(1, 0, 2, 0, 4), 16'h0000, 16'h8000, 16'h0200,
               32'h00400000, 4'h2, 31, 10);
    endtask : t_pause

    initial begin
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        t_unsigned();
        t_signed();
        t_fraction();
        t_zero_div();
        t_pause();
        close_out();
    end

    initial begin
        repeat (5000) @(posedge clk_i);
        fail_count++;
        close_out();
    end
endmodule : dvu_divide_unit_test
`default_nettype wire
